// ==== emb_bus_map.svh ====
// Constants of the external memory bus engine: timing counts and field positions
`ifndef EMB_BUS_MAP_SVH
`define EMB_BUS_MAP_SVH

// ****************************************
// Timing
// ****************************************
// Core clock period and instruction cycle, in nanoseconds
`define EMB_CLK_NS 4
`define EMB_TCY_NS 32
// Instruction cycle in core clocks
`define EMB_TCY_CLKS (`EMB_TCY_NS / `EMB_CLK_NS)
// Half an instruction cycle: one byte slot of an 8-bit fetch
`define EMB_HALF_CLKS (`EMB_TCY_CLKS / 2)
// Wait states after reset when the core gives no other figure
`define EMB_WAIT_DEFAULT 2'h3

// ****************************************
// Field layout
// ****************************************
`define EMB_PTR_W 17
`define EMB_BUS_W 16
`define EMB_CNT_W 6
`define EMB_FIFO_DEPTH 32
// Request word: {op[1:0], pointer[16:0], latch[7:0]}
`define EMB_REQ_W 27
`define EMB_REQ_OP_MSB 26
`define EMB_REQ_OP_LSB 25
`define EMB_REQ_PTR_MSB 24
`define EMB_REQ_PTR_LSB 8
`define EMB_REQ_LAT_MSB 7
`define EMB_REQ_LAT_LSB 0

`endif

// ==== emb_pkg.sv ====
// Types shared by the external memory bus engine
package emb_pkg;

   // Core operation carried to the bus
   typedef enum logic [1:0] {
      EMB_OP_FETCH,
      EMB_OP_TREAD,
      EMB_OP_TWRITE,
      EMB_OP_NONE
   } emb_op_type;

   // Width mode field encoding for the 16-bit bus
   typedef enum logic [1:0] {
      EMB_WM_BYTE_WRITE = 2'h0,
      EMB_WM_WORD_WRITE = 2'h1,
      EMB_WM_BYTE_SEL = 2'h2,
      EMB_WM_SPARE = 2'h3
   } emb_wm_type;

endpackage

// ==== emb_fifo.sv ====
// Request FIFO with registered read data
`timescale 1ns/1ps
module emb_fifo #(
   parameter int WIDTH = 27,
   parameter int DEPTH = 32
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_ptr_q;
   logic [PW-1:0] rd_ptr_q;
   logic [CW-1:0] count_q;
   logic out_valid_q;
   logic [WIDTH-1:0] out_data_q;
   wire push = in_valid && in_ready;
   wire load = (count_q != '0) && (!out_valid_q || out_ready);

   // Honest full: the storage array alone decides it
   assign in_ready = (count_q != CW'(DEPTH));
   assign out_valid = out_valid_q;
   assign out_data = out_data_q;

   // Storage array has no reset; the pointers, fill level and output register do
   always_ff @(posedge clock) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   // Pointers and fill level
   always_ff @(posedge clock) begin
      if (rst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         wr_ptr_q <= push ? PW'(wr_ptr_q + 1'b1) : wr_ptr_q;
         rd_ptr_q <= load ? PW'(rd_ptr_q + 1'b1) : rd_ptr_q;
         count_q <= CW'(count_q + CW'(push) - CW'(load));
      end
   end

   // Output register refills whenever it drains
   always_ff @(posedge clock) begin
      if (rst) begin
         out_valid_q <= 1'b0;
         out_data_q <= '0;
      end else if (load) begin
         out_valid_q <= 1'b1;
         out_data_q <= mem_q[rd_ptr_q];
      end else if (out_ready) begin
         out_valid_q <= 1'b0;
      end
   end
endmodule

// ==== emb_bus.sv ====
// External memory bus engine: fetch, table read and table write over the muxed bus
//
// Notes on behaviour
// - Word-write even address: latch byte, float, no strobe
// - Word-write odd address: latch high, held byte low
// - Word-write: high strobe on odd address only, both byte selects
// - Word-write: byte address still follows pointer bit
// - Byte-select: latch on both halves, high strobe
// - Byte-select: byte address and selects follow pointer
// - 8-bit width: multiplexed, data on low lines
// - 8-bit fetch: two byte slots per cycle
// - Address latch, read byte, toggle bit, read again
// - Chip enable low per access, high asleep
// - Reduced-speed run: timing follows the clock
// - Sleep or idle: stop and freeze the bus
// - Sleep or idle: chip enable, selects forced high
// - Width mode field picks the 16-bit write flavour
// - Byte-write: latch on both, strobe per bit
// - Wait states stretch each data slot 0..3 instruction cycles
`timescale 1ns/1ps
`include "emb_bus_map.svh"
module emb_bus (
   input wire logic clock,
   input wire logic rst,
   input wire logic req_valid,
   output logic req_ready,
   input wire emb_pkg::emb_op_type req_op,
   input wire logic [16:0] req_table_pointer,
   input wire logic [7:0] req_table_latch,
   output logic rsp_valid,
   output logic [15:0] rsp_data,
   input wire emb_pkg::emb_wm_type width_mode_field,
   input wire logic data_width_8,
   input wire logic wait_enable,
   input wire logic [1:0] wait_count,
   input wire logic sleep_idle,
   input wire logic [15:0] muxed_addr_data_bus_in,
   output logic [15:0] muxed_addr_data_bus_out,
   output logic [1:0] muxed_addr_data_bus_oe,
   output logic address_latch_enable,
   output logic output_enable_n,
   output logic write_high_strobe_n,
   output logic write_low_strobe_n,
   output logic chip_enable_n,
   output logic upper_byte_select_n,
   output logic lower_byte_select_n,
   output logic byte_address_bit,
   output logic busy
);
   import emb_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ALE,
      ST_ADDR,
      ST_DATA,
      ST_GAP,
      ST_DONE
   } emb_state_type;

   // ****************************************
   // Helpers
   // ****************************************
   // Length of one data slot including wait states
   function automatic logic [`EMB_CNT_W-1:0] slot_len(input logic width8, input logic wen,
                                                       input logic [1:0] wcnt);
      logic [`EMB_CNT_W-1:0] base;
      logic [`EMB_CNT_W-1:0] extra;
      base = width8 ? `EMB_CNT_W'(`EMB_HALF_CLKS) : `EMB_CNT_W'(`EMB_TCY_CLKS);
      extra = wen ? `EMB_CNT_W'(wcnt * `EMB_TCY_CLKS) : '0;
      slot_len = `EMB_CNT_W'(base + extra);
   endfunction

   // ****************************************
   // Request FIFO
   // ****************************************
   logic fifo_valid;
   logic [`EMB_REQ_W-1:0] fifo_data;
   logic pop;

   emb_fifo #(
      .WIDTH(`EMB_REQ_W),
      .DEPTH(`EMB_FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .rst(rst),
      .in_valid(req_valid),
      .in_ready(req_ready),
      .in_data({req_op, req_table_pointer, req_table_latch}),
      .out_valid(fifo_valid),
      .out_ready(pop),
      .out_data(fifo_data)
   );

   // ****************************************
   // State
   // ****************************************
   emb_state_type state_q, state_d;
   logic [`EMB_CNT_W-1:0] cnt_q, cnt_d;
   emb_op_type op_q;
   logic [16:0] ptr_q;
   logic [7:0] latch_q;
   logic second_q;
   logic [7:0] hold_q;
   logic [15:0] rsp_data_q, rsp_data_d;
   logic rsp_valid_q;
   logic [15:0] sync1_q, sync2_q;
   logic [15:0] ad_q, ad_d;
   logic [1:0] ad_oe_q, ad_oe_d;
   logic ale_q, ale_d;
   logic oe_n_q, oe_n_d;
   logic wrh_n_q, wrh_n_d;
   logic wrl_n_q, wrl_n_d;
   logic ce_n_q, ce_n_d;
   logic ub_n_q, ub_n_d;
   logic lb_n_q, lb_n_d;
   logic ba_q, ba_d;

   // Decoded operation and mode
   wire run = !sleep_idle;
   wire is_write = (op_q == EMB_OP_TWRITE);
   wire is_fetch = (op_q == EMB_OP_FETCH);
   wire odd = ptr_q[0];
   wire wm_word = !data_width_8 && (width_mode_field == EMB_WM_WORD_WRITE);
   wire wm_bsel = !data_width_8 && (width_mode_field == EMB_WM_BYTE_SEL);
   wire wm_bwr = !data_width_8 && !wm_word && !wm_bsel;
   wire slot_end = (cnt_q == `EMB_CNT_W'(1));
   wire two_bytes = data_width_8 && is_fetch;
   wire [`EMB_CNT_W-1:0] slot = slot_len(data_width_8, wait_enable, wait_count);
   wire [1:0] fifo_op = fifo_data[`EMB_REQ_OP_MSB:`EMB_REQ_OP_LSB];

   // New work is taken only from idle and never while asleep
   assign pop = (state_q == ST_IDLE) && run && fifo_valid;

   // Pin inputs cross two flip-flops before use
   always_ff @(posedge clock) begin
      if (rst) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= muxed_addr_data_bus_in;
         sync2_q <= sync1_q;
      end
   end

   // ****************************************
   // Sequencer
   // ****************************************
   // Slot lengths are counted in core clocks, so a slower clock stretches every access
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         ST_IDLE: begin
            if (pop) begin
               state_d = ST_ALE;
            end
         end
         ST_ALE: begin
            state_d = ST_ADDR;
         end
         ST_ADDR: begin
            state_d = ST_DATA;
            cnt_d = slot;
         end
         ST_DATA: begin
            if (!slot_end) begin
               cnt_d = `EMB_CNT_W'(cnt_q - 1'b1);
            end else if (two_bytes && !second_q) begin
               state_d = ST_GAP;
            end else begin
               state_d = ST_DONE;
            end
         end
         ST_GAP: begin
            state_d = ST_DATA;
            cnt_d = slot;
         end
         ST_DONE: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // Read capture: synchronised pins sampled at the last clock of the slot
   always_comb begin
      rsp_data_d = rsp_data_q;
      if (state_q == ST_DATA && slot_end && !is_write) begin
         if (data_width_8 && !second_q) begin
            rsp_data_d = {8'h00, sync2_q[7:0]};
         end else if (data_width_8) begin
            rsp_data_d = is_fetch ? {sync2_q[7:0], rsp_data_q[7:0]} : {8'h00, sync2_q[7:0]};
         end else if (is_fetch) begin
            rsp_data_d = sync2_q;
         end else begin
            rsp_data_d = {8'h00, odd ? sync2_q[15:8] : sync2_q[7:0]};
         end
      end
   end

   // ****************************************
   // Pin drive
   // ****************************************
   // Default is the parked bus: strobes high, latch and byte bit low, address held
   always_comb begin
      ad_d = ad_q;
      ad_oe_d = 2'h0;
      ale_d = 1'b0;
      oe_n_d = 1'b1;
      wrh_n_d = 1'b1;
      wrl_n_d = 1'b1;
      ce_n_d = 1'b1;
      ub_n_d = 1'b1;
      lb_n_d = 1'b1;
      ba_d = 1'b0;
      case (state_q)
         ST_ALE, ST_ADDR: begin
            ad_d = ptr_q[16:1];
            ad_oe_d = 2'h3;
            ale_d = (state_q == ST_ALE);
            ce_n_d = 1'b0;
            ba_d = two_bytes ? 1'b0 : odd;
            ub_n_d = 1'b0;
            lb_n_d = 1'b0;
         end
         ST_DATA, ST_GAP: begin
            ce_n_d = 1'b0;
            // The byte bit turns over in the gap, so it is settled before the second read enable
            ba_d = two_bytes ? (second_q || state_q == ST_GAP) : odd;
            ub_n_d = wm_bsel && is_write && !odd;
            lb_n_d = wm_bsel && is_write && odd;
            if (data_width_8) begin
               // Upper lines keep the address; only the low byte turns around
               ad_oe_d = {1'b1, is_write};
               ad_d = is_write ? {ptr_q[16:9], latch_q} : ad_q;
               wrl_n_d = !(is_write && state_q == ST_DATA);
               oe_n_d = is_write || (state_q == ST_GAP);
            end else if (!is_write) begin
               oe_n_d = 1'b0;
            end else if (wm_word && !odd) begin
               ad_oe_d = 2'h0;
            end else if (wm_word) begin
               ad_d = {latch_q, hold_q};
               ad_oe_d = 2'h3;
               wrh_n_d = 1'b0;
            end else begin
               ad_d = {latch_q, latch_q};
               ad_oe_d = 2'h3;
               wrh_n_d = !(wm_bsel || odd);
               wrl_n_d = !(wm_bwr && !odd);
            end
         end
         default: begin
            ad_d = ad_q;
         end
      endcase
   end

   // Sequencer registers; asleep, everything holds where it was
   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
      end else if (run) begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // Request capture and byte slot tracking
   always_ff @(posedge clock) begin
      if (rst) begin
         op_q <= EMB_OP_NONE;
         ptr_q <= '0;
         latch_q <= '0;
         second_q <= 1'b0;
      end else if (pop) begin
         op_q <= emb_op_type'(fifo_op);
         ptr_q <= fifo_data[`EMB_REQ_PTR_MSB:`EMB_REQ_PTR_LSB];
         latch_q <= fifo_data[`EMB_REQ_LAT_MSB:`EMB_REQ_LAT_LSB];
         second_q <= 1'b0;
      end else if (run && state_q == ST_GAP) begin
         second_q <= 1'b1;
      end
   end

   // Even word-write bytes park here; odd writes leave it untouched
   always_ff @(posedge clock) begin
      if (rst) begin
         hold_q <= '0;
      end else if (run && state_q == ST_ADDR && is_write && wm_word && !odd) begin
         hold_q <= latch_q;
      end
   end

   // Answer to the core
   always_ff @(posedge clock) begin
      if (rst) begin
         rsp_data_q <= '0;
         rsp_valid_q <= 1'b0;
      end else begin
         rsp_data_q <= run ? rsp_data_d : rsp_data_q;
         rsp_valid_q <= run && (state_q == ST_DONE) && !is_write;
      end
   end

   // Pin registers freeze while asleep
   always_ff @(posedge clock) begin
      if (rst) begin
         ad_q <= '0;
         ad_oe_q <= 2'h0;
         ale_q <= 1'b0;
         oe_n_q <= 1'b1;
         wrh_n_q <= 1'b1;
         wrl_n_q <= 1'b1;
         ce_n_q <= 1'b1;
         ub_n_q <= 1'b1;
         lb_n_q <= 1'b1;
         ba_q <= 1'b0;
      end else if (run) begin
         ad_q <= ad_d;
         ad_oe_q <= ad_oe_d;
         ale_q <= ale_d;
         oe_n_q <= oe_n_d;
         wrh_n_q <= wrh_n_d;
         wrl_n_q <= wrl_n_d;
         ce_n_q <= ce_n_d;
         ub_n_q <= ub_n_d;
         lb_n_q <= lb_n_d;
         ba_q <= ba_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Chip enable and byte selects are the only pins released on sleep
   assign chip_enable_n = ce_n_q || sleep_idle;
   assign upper_byte_select_n = ub_n_q || sleep_idle;
   assign lower_byte_select_n = lb_n_q || sleep_idle;
   assign muxed_addr_data_bus_out = ad_q;
   assign muxed_addr_data_bus_oe = ad_oe_q;
   assign address_latch_enable = ale_q;
   assign output_enable_n = oe_n_q;
   assign write_high_strobe_n = wrh_n_q;
   assign write_low_strobe_n = wrl_n_q;
   assign byte_address_bit = ba_q;
   assign rsp_valid = rsp_valid_q;
   assign rsp_data = rsp_data_q;
   assign busy = (state_q != ST_IDLE) || fifo_valid;
endmodule

// ==== emb_bus_sva.sv ====
// Pin-level checker of the external memory bus engine
`timescale 1ns/1ps
module emb_bus_chk (
   input wire logic clock,
   input wire logic rst,
   input wire emb_pkg::emb_wm_type width_mode_field,
   input wire logic data_width_8,
   input wire logic wait_enable,
   input wire logic [1:0] wait_count,
   input wire logic sleep_idle,
   input wire logic [15:0] muxed_addr_data_bus_out,
   input wire logic [1:0] muxed_addr_data_bus_oe,
   input wire logic address_latch_enable,
   input wire logic output_enable_n,
   input wire logic write_high_strobe_n,
   input wire logic write_low_strobe_n,
   input wire logic chip_enable_n,
   input wire logic upper_byte_select_n,
   input wire logic lower_byte_select_n,
   input wire logic byte_address_bit
);
   import emb_pkg::*;
   // ********
   // Checks
   // ********
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   logic [6:0] low_q;
   logic slept_q;
   // Mode decodes and the expected read slot length
   wire ww = !data_width_8 && width_mode_field == EMB_WM_WORD_WRITE;
   wire bs = !data_width_8 && width_mode_field == EMB_WM_BYTE_SEL;
   wire bw = !data_width_8 && !ww && !bs;
   wire halves = muxed_addr_data_bus_out[15:8] == muxed_addr_data_bus_out[7:0];
   wire [6:0] slot_w = (data_width_8 ? 7'h04 : 7'h08) + {2'h0, wait_enable ? wait_count : 2'h0, 3'h0};
   // Counts read-enable cycles; a sleep inside the slot voids the count
   always_ff @(posedge clock) begin
      low_q <= (rst || output_enable_n) ? 7'h00 : low_q + {6'h00, !sleep_idle};
      slept_q <= (rst || output_enable_n) ? 1'h0 : slept_q | sleep_idle;
   end
   sleep_hold_a:
      assert property (sleep_idle && $past(sleep_idle) && $past(sleep_idle, 2) |-> $stable(muxed_addr_data_bus_out)
         && $stable(muxed_addr_data_bus_oe) && $stable(output_enable_n) && $stable(write_high_strobe_n)
         && $stable(write_low_strobe_n) && $stable(address_latch_enable) && $stable(byte_address_bit))
      else $error("bus moved while asleep");
   sleep_high_a:
      assert property (sleep_idle |-> chip_enable_n && upper_byte_select_n && lower_byte_select_n)
      else $error("enable or select low while asleep");
   word_write_a:
      assert property (ww && !write_high_strobe_n |-> write_low_strobe_n && !upper_byte_select_n
         && !lower_byte_select_n && byte_address_bit && muxed_addr_data_bus_oe == 2'h3)
      else $error("word write strobe with wrong selects");
   word_float_a:
      assert property (ww && !chip_enable_n && output_enable_n && muxed_addr_data_bus_oe == 2'h0
         |-> write_high_strobe_n && write_low_strobe_n)
      else $error("word write strobe while bus floats");
   byte_sel_a:
      assert property (bs && !write_high_strobe_n |-> write_low_strobe_n && halves
         && upper_byte_select_n == !byte_address_bit && lower_byte_select_n == byte_address_bit)
      else $error("byte select write lanes wrong");
   byte_write_a:
      assert property (bw && !(write_high_strobe_n && write_low_strobe_n) |-> halves
         && write_high_strobe_n != write_low_strobe_n && write_low_strobe_n == byte_address_bit)
      else $error("byte write strobe does not follow byte bit");
   narrow_bus_a:
      assert property (data_width_8 |-> write_high_strobe_n && (write_low_strobe_n || muxed_addr_data_bus_oe[0]))
      else $error("narrow bus uses the high lane");
   ale_pulse_a:
      assert property ($rose(address_latch_enable) && !sleep_idle |-> !chip_enable_n
         ##1 (!address_latch_enable || sleep_idle))
      else $error("address strobe without enable or too long");
   slot_len_a:
      assert property ($rose(output_enable_n) && !slept_q |-> low_q == slot_w)
      else $error("read slot length wrong");
   byte_swap_a:
      assert property (data_width_8 && $rose(output_enable_n) && !chip_enable_n && !$past(byte_address_bit)
         |-> byte_address_bit ##1 !output_enable_n)
      else $error("second byte of fetch not started");
endmodule
bind emb_bus emb_bus_chk u_chk (.clock, .rst, .width_mode_field, .data_width_8, .wait_enable, .wait_count,
   .sleep_idle, .muxed_addr_data_bus_out, .muxed_addr_data_bus_oe, .address_latch_enable, .output_enable_n,
   .write_high_strobe_n, .write_low_strobe_n, .chip_enable_n, .upper_byte_select_n, .lower_byte_select_n,
   .byte_address_bit);

// ==== emb_mem_model.sv ====
// Behavioural external memory with zero access time, read-only pattern contents
`timescale 1ns/1ps
module emb_mem_model (
   input wire logic clock,
   input wire logic [15:0] muxed_addr_data_bus_out,
   input wire logic [1:0] muxed_addr_data_bus_oe,
   input wire logic address_latch_enable,
   input wire logic output_enable_n,
   input wire logic chip_enable_n,
   input wire logic byte_address_bit,
   input wire logic data_width_8,
   output logic [15:0] ad_bus
);
   // ********
   // Memory
   // ********
   logic [15:0] addr_q;
   logic [15:0] last_q = 16'h0000;
   // Data only while selected and read-enabled; byte bit wired only on the narrow bus
   wire rd_en = !chip_enable_n && !output_enable_n;
   wire [7:0] lo_w = {addr_q[6:0], data_width_8 & byte_address_bit} ^ 8'h5A;
   wire [7:0] hi_w = {addr_q[6:0], 1'h1} ^ 8'h5A;
   // Controller wins a lane it drives; a lane nobody drives wanders so stale data never passes
   assign ad_bus[15:8] = muxed_addr_data_bus_oe[1] ? muxed_addr_data_bus_out[15:8] : rd_en ? hi_w : ~last_q[15:8];
   assign ad_bus[7:0] = muxed_addr_data_bus_oe[0] ? muxed_addr_data_bus_out[7:0] : rd_en ? lo_w : ~last_q[7:0];
   // Word address is taken while the address strobe is high
   always_ff @(posedge clock) begin
      if (address_latch_enable) addr_q <= muxed_addr_data_bus_out;
      last_q <= ad_bus;
   end
endmodule

// ==== external_memory_bus_modes_tb.sv ====
// Self-checking bench of the external memory bus engine
`timescale 1ns/1ps
module external_memory_bus_modes_tb;
   import emb_pkg::*;
   // ********
   // Bench
   // ********
   logic clock, rst, req_valid, data_width_8, wait_enable, sleep_idle, req_ready, rsp_valid, busy;
   logic address_latch_enable, output_enable_n, write_high_strobe_n, write_low_strobe_n;
   logic chip_enable_n, upper_byte_select_n, lower_byte_select_n, byte_address_bit;
   emb_op_type req_op;
   emb_wm_type width_mode_field;
   logic [16:0] req_table_pointer, p;
   logic [7:0] req_table_latch, held;
   logic [1:0] wait_count, muxed_addr_data_bus_oe, prev_s;
   logic [15:0] rsp_data, muxed_addr_data_bus_out, ad_bus;
   logic [22:0] e, g;
   logic [15:0] rsp_q[$];
   logic [22:0] wr_q[$];
   logic [31:0] seed, r;
   int n_errors, tests_run, cyc, k;
   emb_bus u_dut (.clock, .rst, .req_valid, .req_ready, .req_op, .req_table_pointer, .req_table_latch, .rsp_valid,
      .rsp_data, .width_mode_field, .data_width_8, .wait_enable, .wait_count, .sleep_idle,
      .muxed_addr_data_bus_in(ad_bus), .muxed_addr_data_bus_out, .muxed_addr_data_bus_oe, .address_latch_enable,
      .output_enable_n, .write_high_strobe_n, .write_low_strobe_n, .chip_enable_n, .upper_byte_select_n,
      .lower_byte_select_n, .byte_address_bit, .busy);
   emb_mem_model u_mem (.clock, .muxed_addr_data_bus_out, .muxed_addr_data_bus_oe, .address_latch_enable,
      .output_enable_n, .chip_enable_n, .byte_address_bit, .data_width_8, .ad_bus);
   // Free-running core clock
   initial begin
      clock = 1'h0;
      forever #2 clock = ~clock;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [7:0] byt(input logic [16:0] a);
      return a[7:0] ^ 8'h5A;
   endfunction
   task automatic chk_rd(input string what, input logic [15:0] ex, input logic [15:0] gt);
      tests_run++;
      if (gt !== ex) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, ex, gt);
      end
   endtask
   task automatic chk_wr(input logic [22:0] ex, input logic [22:0] gt);
      tests_run++;
      if (gt !== ex) begin
         n_errors++;
         $display("[FAIL] write pins expected %h seen %h", ex, gt);
      end
   endtask
   task automatic complete_run();
      $display("mismatches %0d, checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Offer a request until taken; the reference model queues what it must produce
   task automatic send(input emb_op_type op, input logic [16:0] a, input logic [7:0] lat);
      int w;
      w = 0;
      req_valid = 1'h1;
      req_op = op;
      req_table_pointer = a;
      req_table_latch = lat;
      while (req_ready !== 1'h1 && w < 2000) begin
         @(negedge clock);
         w++;
      end
      @(negedge clock);
      if (op == EMB_OP_FETCH) rsp_q.push_back({byt(a | 17'h1), byt(a)});
      else if (op == EMB_OP_TREAD) rsp_q.push_back({8'h00, byt(a)});
      else if (data_width_8) wr_q.push_back({6'h18, a[0], 8'h00, lat});
      else if (width_mode_field == EMB_WM_BYTE_SEL) wr_q.push_back({4'h9, ~a[0], a[0], a[0], lat, lat});
      else if (width_mode_field != EMB_WM_WORD_WRITE) wr_q.push_back({2'h0, ~a[0], a[0], 2'h0, a[0], lat, lat});
      else if (a[0]) wr_q.push_back({7'h49, lat, held});
      else held = lat;
   endtask
   task automatic drain();
      int w;
      w = 0;
      while ((busy !== 1'h0 || rsp_q.size() > 0 || wr_q.size() > 0) && w < 5000) begin
         @(negedge clock);
         w++;
      end
      repeat (4) @(negedge clock);
   endtask
   // Pins are looked at mid-cycle, after the edge's updates have landed
   always @(negedge clock) begin
      if (!rst && rsp_valid === 1'h1) chk_rd("read data", rsp_q.size() > 0 ? rsp_q.pop_front() : ~rsp_data, rsp_data);
      if ({write_high_strobe_n, write_low_strobe_n} != 2'h3 && prev_s == 2'h3 && !sleep_idle) begin
         e = wr_q.size() > 0 ? wr_q.pop_front() : 23'h7FFFFF;
         g = {e[22:21], write_high_strobe_n, write_low_strobe_n, e[22] ? {upper_byte_select_n, lower_byte_select_n}
            : e[18:17], byte_address_bit, e[21] ? e[15:8] : ad_bus[15:8], ad_bus[7:0]};
         chk_wr(e, g);
      end
      prev_s = {write_high_strobe_n, write_low_strobe_n};
   end
   // Hang guard
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         complete_run();
      end
   end
   // Main sequence: every width mode, with waits in the word-write and 8-bit runs only, then a sleep in mid-read that fills the queue
   initial begin
      seed = 32'hB5266EA1;
      n_errors = 0;
      tests_run = 0;
      cyc = 0;
      prev_s = 2'h3;
      held = 8'h00;
      rst = 1'h1;
      req_valid = 1'h0;
      req_op = EMB_OP_FETCH;
      req_table_pointer = 17'h00000;
      req_table_latch = 8'h00;
      width_mode_field = EMB_WM_BYTE_WRITE;
      data_width_8 = 1'h0;
      wait_enable = 1'h0;
      wait_count = 2'h3;
      sleep_idle = 1'h0;
      repeat (4) @(negedge clock);
      rst = 1'h0;
      for (int m = 0; m < 5; m++) begin
         width_mode_field = emb_wm_type'(m[1:0]);
         data_width_8 = (m == 4);
         wait_enable = (m == 1 || m == 4);
         wait_count = (m == 1) ? 2'h3 : 2'h1;
         for (int i = 0; i < 9; i++) begin
            r = xs();
            p = r[16:0];
            if (i % 3 == 0) p[0] = 1'h0;
            if (i % 3 == 1 && data_width_8) p[0] = 1'h1;
            if (m == 1 && i % 3 == 2) begin
               send(EMB_OP_TWRITE, p & 17'h1FFFE, r[31:24]);
               send(EMB_OP_TWRITE, p | 17'h00001, r[7:0]);
               send(EMB_OP_TWRITE, p | 17'h00001, r[15:8]);
            end else begin
               send(emb_op_type'(i % 3), p, r[31:24]);
            end
         end
         req_valid = 1'h0;
         drain();
      end
      width_mode_field = EMB_WM_BYTE_SEL;
      data_width_8 = 1'h0;
      wait_enable = 1'h0;
      send(EMB_OP_FETCH, 17'h000A4, 8'h00);
      req_valid = 1'h0;
      k = 0;
      while (output_enable_n !== 1'h0 && k < 100) begin
         @(negedge clock);
         k++;
      end
      repeat (2) @(negedge clock);
      sleep_idle = 1'h1;
      k = 0;
      while (req_ready === 1'h1 && k < 40) begin
         r = xs();
         send(EMB_OP_TREAD, r[16:0], 8'h00);
         k++;
      end
      req_valid = 1'h0;
      chk_rd("queue depth", 16'h0021, k[15:0]);
      repeat (20) @(negedge clock);
      sleep_idle = 1'h0;
      drain();
      chk_rd("left over", 16'h0000, 16'(rsp_q.size() + wr_q.size()));
      complete_run();
   end
endmodule
